// [dv/acmp_analog_model.sv]
`timescale 1ns/1ns
module acmp_analog_model #(parameter int BANDGAP = 120) (
  input wire logic comparatorPowerOff,
  input wire logic bandgapPositiveSelect,
  input wire logic negativeFromMux,
  input wire logic [2:0] negativeChannel,
  input wire logic captureSource,
  input wire logic [31:0] pinPos,
  input wire logic [31:0] pinNeg,
  output logic compareRaw,
  output int capCount
);
  int posLvl;
  int negLvl;
  // input steering; mux channel n sits at 100 plus 10 per step
  assign posLvl = bandgapPositiveSelect ? BANDGAP : pinPos;
  assign negLvl = negativeFromMux ? 100 + 10 * negativeChannel : pinNeg;
  // an unpowered core makes no decision, seen as low
  assign compareRaw = !comparatorPowerOff && posLvl > negLvl;
  // timer front end counts rising captures; its capture interrupt enable is taken as set
  always @(posedge captureSource) capCount++;
endmodule

// [dv/acmp_ctrl_props.sv]
`timescale 1ns/1ns
module acmp_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ioSpace,
  input wire logic [7:0] busAddr,
  input wire acmp_pkg::acmp_byte_t busWdata,
  input wire logic busWe,
  input wire logic busRe,
  input wire acmp_pkg::acmp_byte_t busRdata,
  input wire logic converterEnable,
  input wire logic [2:0] channelSelectBits,
  input wire logic cpuGlobalIrq,
  input wire logic compareRaw,
  input wire logic comparatorPowerOff,
  input wire logic negativeFromMux,
  input wire logic [2:0] negativeChannel,
  input wire logic comparatorIrq,
  input wire logic captureSource,
  input wire logic captureRouteActive
);
  import acmp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ********
  // port relations
  // ********
  power_write_a: assert property (
    busWe && busAddr == (ioSpace ? 8'h08 : 8'h28) |=> comparatorPowerOff == $past(busWdata[7])) else $error("power bit");
  irq_global_a: assert property (
    !cpuGlobalIrq |=> !comparatorIrq) else $error("request without global enable");
  mux_off_a: assert property (
    converterEnable |=> !negativeFromMux) else $error("mux while converter on");
  chan_zero_a: assert property (
    !negativeFromMux |-> negativeChannel == 3'h0) else $error("channel not parked");
  chan_pick_a: assert property (
    negativeFromMux |-> negativeChannel == $past(channelSelectBits)) else $error("wrong channel");
  rdata_idle_a: assert property (
    !busRe |=> busRdata == 8'h00) else $error("read data not idle");
  cap_off_a: assert property (
    !captureRouteActive |-> !captureSource) else $error("capture leaks");
  // six quiet samples cover the two-stage sync plus the output register
  cap_follow_a: assert property (
    $stable(compareRaw)[*6] ##0 captureRouteActive |-> captureSource == compareRaw) else $error("capture stale");
endmodule
bind acmp_ctrl acmp_ctrl_chk chk (.sys_clk, .rst_b, .ioSpace, .busAddr, .busWdata, .busWe, .busRe, .busRdata,
  .converterEnable, .channelSelectBits, .cpuGlobalIrq, .compareRaw, .comparatorPowerOff, .negativeFromMux,
  .negativeChannel, .comparatorIrq, .captureSource, .captureRouteActive);

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import acmp_pkg::*;
  logic sys_clk = 0, rst_b = 0, ioSpace = 0, busWe = 0, busRe = 0, converterEnable = 0, cpuGlobalIrq = 0;
  logic vectorAck = 0, compareRaw, comparatorPowerOff, bandgapPositiveSelect, negativeFromMux, comparatorIrq;
  logic captureSource, captureRouteActive;
  logic [7:0] busAddr = 8'h00;
  acmp_byte_t busWdata = 8'h00, busRdata;
  logic [2:0] channelSelectBits = 3'h0, negativeChannel;
  int pinPos = 0, pinNeg = 50, capCount, n_errors = 0, compares = 0, cycles = 0, m;
  acmp_ctrl dut (.sys_clk, .rst_b, .ioSpace, .busAddr, .busWdata, .busWe, .busRe, .busRdata, .converterEnable,
    .channelSelectBits, .cpuGlobalIrq, .vectorAck, .compareRaw, .comparatorPowerOff, .bandgapPositiveSelect,
    .negativeFromMux, .negativeChannel, .comparatorIrq, .captureSource, .captureRouteActive);
  acmp_analog_model core (.comparatorPowerOff, .bandgapPositiveSelect, .negativeFromMux, .negativeChannel,
    .captureSource, .pinPos, .pinNeg, .compareRaw, .capCount);
  // ********
  // clock, guard and access tasks
  // ********
  always #5 sys_clk = ~sys_clk;
  // hang guard at 3000 cycles, far above the fewer than two hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // one strobe cycle; a gap cycle follows so strobes never re-rise in the same step
  task automatic acc(input logic w, input logic io, input logic [7:0] a, input acmp_byte_t d);
    @(negedge sys_clk);
    ioSpace = io;
    busAddr = a;
    busWdata = d;
    busWe = w;
    busRe = !w;
    @(negedge sys_clk);
    busWe = 0;
    busRe = 0;
  endtask
  task automatic rd(input logic io, input logic [7:0] a, input acmp_byte_t e);
    acc(0, io, a, 8'h00);
    chk(busRdata, e);
  endtask
  task automatic settle();
    repeat (5) @(negedge sys_clk);
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_b = 1;
    rd(1, 8'h08, 8'h00);
    rd(0, 8'h40, 8'h00);
    rd(1, 8'h09, 8'h00);
    acc(1, 0, 8'h28, 8'hE4);
    rd(1, 8'h08, 8'hC4);
    chk({7'h0, comparatorPowerOff}, 8'h01);
    acc(1, 1, 8'h08, 8'h40);
    chk({7'h0, bandgapPositiveSelect}, 8'h01);
    settle();
    rd(0, 8'h28, 8'h70);
    acc(1, 1, 8'h08, 8'h13);
    settle();
    rd(1, 8'h08, 8'h03);
    // the enable stays clear through every mode change
    for (m = 0; m < 4; m++) begin
      acc(1, 1, 8'h08, 8'h10 | m[7:0]);
      pinPos = 100;
      settle();
      rd(1, 8'h08, {3'h1, (m == 0 || m == 3), 2'h0, m[1:0]});
      acc(1, 1, 8'h08, 8'h10 | m[7:0]);
      pinPos = 0;
      settle();
      rd(1, 8'h08, {3'h0, (m == 0 || m == 2), 2'h0, m[1:0]});
    end
    acc(1, 1, 8'h20, 8'hFF);
    rd(0, 8'h40, 8'h08);
    for (m = 0; m < 8; m++) begin
      channelSelectBits = m[2:0];
      @(negedge sys_clk);
      chk({negativeFromMux, 4'h0, negativeChannel}, {5'h10, m[2:0]});
    end
    converterEnable = 1;
    @(negedge sys_clk);
    chk({7'h0, negativeFromMux}, 8'h00);
    acc(1, 1, 8'h08, 8'h1B);
    cpuGlobalIrq = 1;
    pinPos = 200;
    settle();
    chk({7'h0, comparatorIrq}, 8'h01);
    vectorAck = 1;
    @(negedge sys_clk);
    vectorAck = 0;
    rd(1, 8'h08, 8'h2B);
    chk({7'h0, comparatorIrq}, 8'h00);
    pinPos = 0;
    settle();
    cpuGlobalIrq = 0;
    pinPos = 200;
    settle();
    rd(1, 8'h08, 8'h3B);
    chk({7'h0, comparatorIrq}, 8'h00);
    pinPos = 0;
    acc(1, 1, 8'h08, 8'h13);
    settle();
    acc(1, 1, 8'h08, 8'h14);
    chk({7'h0, captureRouteActive}, 8'h01);
    m = capCount;
    pinPos = 200;
    settle();
    chk(8'(capCount - m), 8'h01);
    acc(1, 1, 8'h08, 8'h10);
    chk({7'h0, captureRouteActive}, 8'h00);
    pinPos = 0;
    settle();
    pinPos = 200;
    settle();
    chk(8'(capCount - m), 8'h01);
    tally_and_finish();
  end
endmodule

// [verilog/acmp_ctrl.sv]
`timescale 1ns/1ns
`include "acmp_regs.svh"
module acmp_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ioSpace,
  input wire logic [7:0] busAddr,
  input wire acmp_pkg::acmp_byte_t busWdata,
  input wire logic busWe,
  input wire logic busRe,
  output acmp_pkg::acmp_byte_t busRdata,
  input wire logic converterEnable,
  input wire logic [2:0] channelSelectBits,
  input wire logic cpuGlobalIrq,
  input wire logic vectorAck,
  input wire logic compareRaw,
  output logic comparatorPowerOff,
  output logic bandgapPositiveSelect,
  output logic negativeFromMux,
  output logic [2:0] negativeChannel,
  output logic comparatorIrq,
  output logic captureSource,
  output logic captureRouteActive
);
  import acmp_pkg::*;

  // **************************************************
  // reset images
  // **************************************************
  // flops take their bits from the reset bytes so reset and readback always agree
  localparam acmp_byte_t CsrReset = `ACMP_CSR_RESET;
  localparam acmp_byte_t SfioReset = `ACMP_SFIO_RESET;

  // **************************************************
  // address decode
  // **************************************************
  // io offsets and data-space addresses both land on the same registers
  function automatic logic hitReg(input logic io, input logic [7:0] a, input logic [5:0] ioOfs,
                                  input logic [7:0] dsAddr);
    hitReg = io ? (a == {2'h0, ioOfs}) : (a == dsAddr);
  endfunction

  // two flops stand between the comparator and any logic that reads its level
  acmp_sync_if syncBus ();

  acmp_sync u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rawIn(compareRaw),
    .syncBus(syncBus)
  );

  // combinational decode terms
  logic csrHit;
  logic sfioHit;
  logic eventHit;
  logic riseEdge;
  logic fallEdge;

  // register state and its next value
  logic powerOff_r, powerOff_nxt;
  logic bandgap_r, bandgap_nxt;
  logic flag_r, flag_nxt;
  logic irqEn_r, irqEn_nxt;
  logic capture_r, capture_nxt;
  acmp_mode_t mode_r, mode_nxt;
  logic muxEn_r, muxEn_nxt;
  acmp_byte_t rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic capSrc_r, capSrc_nxt;
  logic negMux_r, negMux_nxt;
  logic [2:0] negCh_r, negCh_nxt;

  // **************************************************
  // event detection
  // **************************************************
  // edges come from the history stage, so each transition is seen on exactly one cycle
  always_comb begin
    csrHit = hitReg(ioSpace, busAddr, `ACMP_CSR_IO_OFS, `ACMP_CSR_DS_ADDR);
    sfioHit = hitReg(ioSpace, busAddr, `ACMP_SFIO_IO_OFS, `ACMP_SFIO_DS_ADDR);
    riseEdge = syncBus.level & ~syncBus.prevLevel;
    fallEdge = ~syncBus.level & syncBus.prevLevel;
    // reserved mode sets nothing
    case (mode_r)
      ACMP_MODE_TOGGLE: eventHit = riseEdge | fallEdge;
      ACMP_MODE_FALL: eventHit = fallEdge;
      ACMP_MODE_RISE: eventHit = riseEdge;
      default: eventHit = 1'b0;
    endcase
  end

  // **************************************************
  // register file next state
  // **************************************************
  // writes, hardware clears and events merge here; later assignments win
  always_comb begin
    powerOff_nxt = powerOff_r;
    bandgap_nxt = bandgap_r;
    irqEn_nxt = irqEn_r;
    capture_nxt = capture_r;
    mode_nxt = mode_r;
    muxEn_nxt = muxEn_r;
    flag_nxt = flag_r;
    // bit 5 is read-only, so a write to it is dropped
    // no interlock against the enable: software quiets the request before changing power or mode
    if (busWe && csrHit) begin
      powerOff_nxt = busWdata[`ACMP_BIT_POWER_OFF];
      bandgap_nxt = busWdata[`ACMP_BIT_BANDGAP];
      irqEn_nxt = busWdata[`ACMP_BIT_IRQ_EN];
      capture_nxt = busWdata[`ACMP_BIT_CAPTURE];
      mode_nxt = acmp_mode_t'(busWdata[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO]);
      // write-one-to-clear; a zero leaves the flag alone
      if (busWdata[`ACMP_BIT_FLAG]) begin
        flag_nxt = 1'b0;
      end
    end
    if (busWe && sfioHit) begin
      muxEn_nxt = busWdata[`ACMP_BIT_MUX_EN];
    end
    if (vectorAck) begin
      flag_nxt = 1'b0;
    end
    // a new event beats a clear in the same cycle so it is never lost
    if (eventHit) begin
      flag_nxt = 1'b1;
    end
  end

  // **************************************************
  // outputs next state
  // **************************************************
  // request and routing use next values so they move on the same edge as the write
  always_comb begin
    // read data stands for one cycle and is zero otherwise
    rdata_nxt = 8'h00;
    if (busRe && csrHit) begin
      rdata_nxt = {powerOff_r, bandgap_r, syncBus.level, flag_r, irqEn_r, capture_r, mode_r};
    end else if (busRe && sfioHit) begin
      rdata_nxt[`ACMP_BIT_MUX_EN] = muxEn_r;
    end
    irq_nxt = flag_nxt & irqEn_nxt & cpuGlobalIrq;
    // gated to zero when routing is off so capture logic sees no comparator activity
    capSrc_nxt = capture_nxt & syncBus.level;
    // a running converter always hands the negative input back to the pin
    negMux_nxt = muxEn_nxt & ~converterEnable;
    negCh_nxt = negMux_nxt ? channelSelectBits : 3'h0;
  end

  // **************************************************
  // register file storage
  // **************************************************
  // software-visible bits; the read-only sync-output bit has no storage of its own
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerOff_r <= CsrReset[`ACMP_BIT_POWER_OFF];
      bandgap_r <= CsrReset[`ACMP_BIT_BANDGAP];
      flag_r <= CsrReset[`ACMP_BIT_FLAG];
      irqEn_r <= CsrReset[`ACMP_BIT_IRQ_EN];
      capture_r <= CsrReset[`ACMP_BIT_CAPTURE];
      mode_r <= acmp_mode_t'(CsrReset[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO]);
      muxEn_r <= SfioReset[`ACMP_BIT_MUX_EN];
    end else begin
      powerOff_r <= powerOff_nxt;
      bandgap_r <= bandgap_nxt;
      flag_r <= flag_nxt;
      irqEn_r <= irqEn_nxt;
      capture_r <= capture_nxt;
      mode_r <= mode_nxt;
      muxEn_r <= muxEn_nxt;
    end
  end

  // **************************************************
  // output storage
  // **************************************************
  // every port leaves from a flop so the analog and timer sides never see decode glitches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      capSrc_r <= 1'b0;
      negMux_r <= 1'b0;
      negCh_r <= 3'h0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      capSrc_r <= capSrc_nxt;
      negMux_r <= negMux_nxt;
      negCh_r <= negCh_nxt;
    end
  end

  // **************************************************
  // port drive
  // **************************************************
  // plain wires from the flops, nothing between flop and pin
  assign busRdata = rdata_r;
  assign comparatorPowerOff = powerOff_r;
  assign bandgapPositiveSelect = bandgap_r;
  assign comparatorIrq = irq_r;
  assign captureSource = capSrc_r;
  assign captureRouteActive = capture_r;
  assign negativeFromMux = negMux_r;
  assign negativeChannel = negCh_r;
endmodule

// [verilog/acmp_pkg.sv]
package acmp_pkg;
  // event mode encoding for the two mode bits
  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE = 2'h0,
    ACMP_MODE_RSVD = 2'h1,
    ACMP_MODE_FALL = 2'h2,
    ACMP_MODE_RISE = 2'h3
  } acmp_mode_t;
  typedef logic [7:0] acmp_byte_t;
endpackage

// [verilog/acmp_regs.svh]
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
// I/O-space offsets
`define ACMP_CSR_IO_OFS 6'h08
`define ACMP_SFIO_IO_OFS 6'h20
// data-space addresses (I/O offset plus 0x20)
`define ACMP_CSR_DS_ADDR 8'h28
`define ACMP_SFIO_DS_ADDR 8'h40
// control/status bit positions
`define ACMP_BIT_POWER_OFF 7
`define ACMP_BIT_BANDGAP 6
`define ACMP_BIT_SYNC_OUT 5
`define ACMP_BIT_FLAG 4
`define ACMP_BIT_IRQ_EN 3
`define ACMP_BIT_CAPTURE 2
`define ACMP_BIT_MODE_HI 1
`define ACMP_BIT_MODE_LO 0
// special function register bit
`define ACMP_BIT_MUX_EN 3
// reset values
`define ACMP_CSR_RESET 8'h00
`define ACMP_SFIO_RESET 8'h00
`endif

// [verilog/acmp_sync.sv]
`timescale 1ns/1ns
module acmp_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rawIn,
  acmp_sync_if.src syncBus
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;
  logic prev_r;
  logic prev_nxt;

  // **************************************************
  // two-stage synchronizer plus one history stage
  // **************************************************
  // the first stage feeds only the second; the history stage enables edge detection
  always_comb begin
    meta_nxt = rawIn;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign syncBus.level = sync_r;
  assign syncBus.prevLevel = prev_r;
endmodule

// [verilog/acmp_sync_if.sv]
`timescale 1ns/1ns
// carries the synchronized comparator level and its previous sample
interface acmp_sync_if;
  logic level;
  logic prevLevel;
  modport src (output level, output prevLevel);
  modport dst (input level, input prevLevel);
endinterface
